//--- design/ast_top.sv
// Local design decisions: the strobed register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "ast_map.svh"

module ast_top (
  input  wire logic       SYS_CLK,
  input  wire logic       RST,
  input  wire logic [2:0] ADDR,
  input  wire logic [7:0] WDATA,
  input  wire logic       WR,
  input  wire logic       RD,
  output wire logic [7:0] RDATA,
  input  wire logic       RX,
  output wire logic       TX,
  output wire logic       TX_OE,
  output wire logic       TX_EMPTY_IRQ,
  output wire logic       TX_DONE_IRQ
);

  ast_pkg::ast_state_s s_reg;     // Registered state
  ast_pkg::ast_state_s n;         // Next state
  logic                tx_os;     // Transmit oversampling tick
  logic                rx_os;     // Receive oversampling tick
  logic                tx_step;   // Transmit tick while enabled
  logic                rx_step;   // Receive tick while enabled
  logic                ten_rise;  // Transmitter just enabled
  logic                rx_fall;   // Falling edge on synchronised input
  logic                tx_ready;  // Idle and free for a direct load
  logic                sr_rd;     // Status read strobe
  logic                sr_wr;     // Status write strobe
  logic                dr_rd;     // Data read strobe
  logic                dr_wr;     // Data write strobe
  logic [3:0]          nbits;     // Data bits per frame
  logic [5:0]          stop_len;  // Stop phase length in ticks
  logic [3:0]          sc;        // Sample counter after this tick
  logic [1:0]          za;        // Low samples in group incl. this one
  logic [1:0]          ob;        // High samples incl. this one

  // Address decode of the strobes
  assign sr_rd = RD && (ADDR == `AST_ADDR_SR);
  assign sr_wr = WR && (ADDR == `AST_ADDR_SR);
  assign dr_rd = RD && (ADDR == `AST_ADDR_DR);
  assign dr_wr = WR && (ADDR == `AST_ADDR_DR);

  // Frame shape helpers
  assign nbits    = s_reg.m ? 4'h9 : 4'h8;
  assign ten_rise = s_reg.transmitter_enable_bit && !s_reg.ten_q;
  assign tx_step  = s_reg.transmitter_enable_bit && tx_os;
  assign rx_step  = s_reg.ren && rx_os;
  assign tx_ready = s_reg.transmitter_enable_bit && s_reg.ten_q && (s_reg.tx_st == ast_pkg::TX_IDLE) && s_reg.tx_buffer_empty_flag && !s_reg.send_break_request;
  assign rx_fall  = s_reg.ren && (s_reg.rx_st == ast_pkg::RX_IDLE) && s_reg.rx_prev && !s_reg.rx_sync2;
  assign sc       = s_reg.scnt + 4'h1;
  assign za       = s_reg.zcnt + {1'b0, !s_reg.rx_sync2};
  assign ob       = s_reg.zcnt + {1'b0, s_reg.rx_sync2};

  // Stop phase length; a break honours only the two-stop code, else one stop bit
  always_comb begin
    if (s_reg.kind == ast_pkg::FR_BREAK) begin
      // First sixteen ticks stay low, then one or two high bits
      stop_len = (s_reg.stop == `AST_STOP_TWO) ? `AST_BRK2_TICKS : `AST_BRK1_TICKS;
    end else if (s_reg.stop == `AST_STOP_TWO) begin
      stop_len = `AST_STOP2_TICKS;
    end else if (s_reg.stop == `AST_STOP_ONEHALF) begin
      stop_len = `AST_STOP15_TICKS;
    end else begin
      stop_len = `AST_STOP1_TICKS;
    end
  end

  // Transmit tick divider, frozen while the transmitter is off
  ast_tick_gen #(.W(16)) u_tx_tick (
    .clk  (SYS_CLK),
    .rst  (RST),
    .en   (s_reg.transmitter_enable_bit),
    .clr  (ten_rise),
    .div  (s_reg.div),
    .tick (tx_os)
  );

  // Receive tick divider, realigned on each falling edge seen while idle
  ast_tick_gen #(.W(16)) u_rx_tick (
    .clk  (SYS_CLK),
    .rst  (RST),
    .en   (s_reg.ren),
    .clr  (rx_fall),
    .div  (s_reg.div),
    .tick (rx_os)
  );

  // Next-state logic for registers, transmitter and receiver
  always_comb begin
    n = s_reg;
    n.ten_q = s_reg.transmitter_enable_bit;
    // Input synchroniser and edge history
    n.rx_sync1 = RX;
    n.rx_sync2 = s_reg.rx_sync1;
    n.rx_prev = s_reg.rx_sync2;
    // Control register writes
    if (WR && (ADDR == `AST_ADDR_CR1)) begin
      n.tx9 = WDATA[`AST_CR1_TX9];
      n.m = WDATA[`AST_CR1_M];
    end else if (WR && (ADDR == `AST_ADDR_CR2)) begin
      n.tx_empty_irq_enable = WDATA[`AST_CR2_TX_EMPTY_IRQ_ENABLE];
      n.tx_complete_irq_enable = WDATA[`AST_CR2_TX_COMPLETE_IRQ_ENABLE];
      n.transmitter_enable_bit = WDATA[`AST_CR2_TEN];
      n.ren = WDATA[`AST_CR2_REN];
      n.send_break_request = WDATA[`AST_CR2_SBK];
    end else if (WR && (ADDR == `AST_ADDR_CR3)) begin
      n.stop = WDATA[`AST_CR3_STOP_MSB:`AST_CR3_STOP_LSB];
    end else if (WR && (ADDR == `AST_ADDR_DIVL)) begin
      n.div[7:0] = WDATA;
    end else if (WR && (ADDR == `AST_ADDR_DIVH)) begin
      n.div[15:8] = WDATA;
    end
    // Status read arms the two-step clears
    if (sr_rd) begin
      n.tc_arm = 1'b1;
      n.nf_arm = 1'b1;
    end
    // Writing zero to the complete flag clears it
    if (sr_wr && !WDATA[`AST_SR_TC]) begin
      n.tc = 1'b0;
    end
    // Data write after a status read clears the complete flag
    if (dr_wr) begin
      if (s_reg.tc_arm) begin
        n.tc = 1'b0;
      end
      n.tc_arm = 1'b0;
    end
    // Data read consumes the received word
    if (dr_rd) begin
      n.rxf = 1'b0;
      if (s_reg.nf_arm) begin
        n.nf = 1'b0;
      end
      n.nf_arm = 1'b0;
    end

    // Transmit sequencer
    if (ten_rise) begin
      // Preamble of all ones after enabling
      n.tx_st = ast_pkg::TX_START;
      n.kind = ast_pkg::FR_IDLE;
      n.tcnt = '0;
      n.bidx = '0;
    end else if (s_reg.transmitter_enable_bit && (s_reg.tx_st == ast_pkg::TX_IDLE)) begin
      if (s_reg.send_break_request) begin
        // Break waits for the frame boundary
        n.tx_st = ast_pkg::TX_START;
        n.kind = ast_pkg::FR_BREAK;
        n.tcnt = '0;
        n.bidx = '0;
      end else if (!s_reg.tx_buffer_empty_flag) begin
        // Holding word moves into the shifter
        n.shift = {s_reg.m & s_reg.tx9, s_reg.hold};
        n.tx_buffer_empty_flag = 1'b1;
        n.tx_st = ast_pkg::TX_START;
        n.kind = ast_pkg::FR_DATA;
        n.tcnt = '0;
        n.bidx = '0;
      end
    end else if (tx_step) begin
      case (s_reg.tx_st)
        ast_pkg::TX_START: begin
          // One whole bit period of start
          if (s_reg.tcnt == `AST_BIT_LAST) begin
            n.tcnt = '0;
            n.tx_st = ast_pkg::TX_DATA;
          end else begin
            n.tcnt = s_reg.tcnt + 6'h01;
          end
        end
        ast_pkg::TX_DATA: begin
          // Shift right so bit zero leaves first
          if (s_reg.tcnt == `AST_BIT_LAST) begin
            n.tcnt = '0;
            n.shift = {1'b0, s_reg.shift[8:1]};
            n.bidx = s_reg.bidx + 4'h1;
            if (s_reg.bidx == nbits - 4'h1) begin
              n.tx_st = ast_pkg::TX_STOP;
              if (s_reg.kind == ast_pkg::FR_BREAK) begin
                // Request drops in the break stop bit unless rewritten now
                n.send_break_request = (WR && (ADDR == `AST_ADDR_CR2)) ? WDATA[`AST_CR2_SBK] : 1'b0;
              end
            end
          end else begin
            n.tcnt = s_reg.tcnt + 6'h01;
          end
        end
        ast_pkg::TX_STOP: begin
          // Stop phase; complete flag when nothing waits
          if (s_reg.tcnt == stop_len - 6'h01) begin
            n.tcnt = '0;
            n.tx_st = ast_pkg::TX_IDLE;
            if (s_reg.tx_buffer_empty_flag) begin
              n.tc = 1'b1;
            end
          end else begin
            n.tcnt = s_reg.tcnt + 6'h01;
          end
        end
        default: begin
          n.tcnt = s_reg.tcnt;
        end
      endcase
    end

    // Data write: direct start when idle, else hold
    if (dr_wr) begin
      if (tx_ready) begin
        n.shift = {s_reg.m & s_reg.tx9, WDATA};
        n.tx_buffer_empty_flag = 1'b1;
        n.tx_st = ast_pkg::TX_START;
        n.kind = ast_pkg::FR_DATA;
        n.tcnt = '0;
        n.bidx = '0;
      end else begin
        n.hold = WDATA;
        n.tx_buffer_empty_flag = 1'b0;
      end
    end

    // Line level follows the next state so pin and state align
    n.tx_line = 1'b1;
    if (n.tx_st == ast_pkg::TX_START) begin
      n.tx_line = (n.kind == ast_pkg::FR_IDLE);
    end else if (n.tx_st == ast_pkg::TX_DATA) begin
      n.tx_line = (n.kind == ast_pkg::FR_DATA) ? n.shift[0] : (n.kind == ast_pkg::FR_IDLE);
    end else if (n.tx_st == ast_pkg::TX_STOP) begin
      // A break keeps the line low through its first stop bit
      n.tx_line = !((n.kind == ast_pkg::FR_BREAK) && !n.tcnt[5] && !n.tcnt[4]);
    end
    n.tx_oe = n.transmitter_enable_bit;

    // Receiver
    if (!s_reg.ren) begin
      n.rx_st = ast_pkg::RX_IDLE;
    end else begin
      case (s_reg.rx_st)
        ast_pkg::RX_IDLE: begin
          // Falling edge counts as the third sample
          if (rx_fall) begin
            n.rx_st = ast_pkg::RX_START;
            n.scnt = `AST_SMP_EDGE;
            n.zcnt = 2'h1;
            n.rnoise = 1'b0;
          end
        end
        ast_pkg::RX_START: begin
          if (rx_step) begin
            n.scnt = sc;
            if (sc == `AST_SMP_A1) begin
              n.zcnt = za;
            end else if (sc == `AST_SMP_A2) begin
              // Third, fifth, seventh samples
              if (za < 2'h2) begin
                n.rx_st = ast_pkg::RX_IDLE;
              end
              n.rnoise = (za != 2'h3);
              n.zcnt = '0;
            end else if ((sc == `AST_SMP_B0) || (sc == `AST_SMP_B1)) begin
              n.zcnt = za;
            end else if (sc == `AST_SMP_B2) begin
              // Eighth, ninth, tenth samples confirm
              if (za < 2'h2) begin
                n.rx_st = ast_pkg::RX_IDLE;
              end else begin
                n.rx_st = ast_pkg::RX_DATA;
                n.rnoise = s_reg.rnoise || (za != 2'h3);
              end
              n.zcnt = '0;
              n.rbits = '0;
            end
          end
        end
        ast_pkg::RX_DATA: begin
          if (rx_step) begin
            n.scnt = sc;
            if ((sc == `AST_SMP_B0) || (sc == `AST_SMP_B1)) begin
              n.zcnt = ob;
            end else if (sc == `AST_SMP_B2) begin
              // Majority vote, noisy when not unanimous
              n.rshift = {ob[1], s_reg.rshift[8:1]};
              n.rnoise = s_reg.rnoise || (ob == 2'h1) || (ob == 2'h2);
              n.zcnt = '0;
              n.rbits = s_reg.rbits + 4'h1;
              if (s_reg.rbits == nbits - 4'h1) begin
                n.rx_st = ast_pkg::RX_STOP;
              end
            end
          end
        end
        ast_pkg::RX_STOP: begin
          if (rx_step) begin
            n.scnt = sc;
            if (sc == `AST_SMP_B2) begin
              // Word delivered; flags set over a same-cycle clear
              n.rx_data = s_reg.m ? s_reg.rshift[7:0] : s_reg.rshift[8:1];
              n.rx9 = s_reg.m & s_reg.rshift[8];
              n.rxf = 1'b1;
              n.nf = n.nf || s_reg.rnoise;
              n.rx_st = ast_pkg::RX_IDLE;
            end
          end
        end
        default: begin
          n.rx_st = ast_pkg::RX_IDLE;
        end
      endcase
    end

    // Read data, valid the cycle after the strobe
    n.rdata = 8'h00;
    if (RD) begin
      if (ADDR == `AST_ADDR_SR) begin
        n.rdata[`AST_SR_TXE] = s_reg.tx_buffer_empty_flag;
        n.rdata[`AST_SR_TC] = s_reg.tc;
        n.rdata[`AST_SR_RXF] = s_reg.rxf;
        n.rdata[`AST_SR_NF] = s_reg.nf;
      end else if (ADDR == `AST_ADDR_DR) begin
        n.rdata = s_reg.rx_data;
      end else if (ADDR == `AST_ADDR_CR1) begin
        n.rdata[`AST_CR1_RX9] = s_reg.rx9;
        n.rdata[`AST_CR1_TX9] = s_reg.tx9;
        n.rdata[`AST_CR1_M] = s_reg.m;
      end else if (ADDR == `AST_ADDR_CR2) begin
        n.rdata[`AST_CR2_TX_EMPTY_IRQ_ENABLE] = s_reg.tx_empty_irq_enable;
        n.rdata[`AST_CR2_TX_COMPLETE_IRQ_ENABLE] = s_reg.tx_complete_irq_enable;
        n.rdata[`AST_CR2_TEN] = s_reg.transmitter_enable_bit;
        n.rdata[`AST_CR2_REN] = s_reg.ren;
        n.rdata[`AST_CR2_SBK] = s_reg.send_break_request;
      end else if (ADDR == `AST_ADDR_CR3) begin
        n.rdata[`AST_CR3_STOP_MSB:`AST_CR3_STOP_LSB] = s_reg.stop;
      end else if (ADDR == `AST_ADDR_DIVL) begin
        n.rdata = s_reg.div[7:0];
      end else if (ADDR == `AST_ADDR_DIVH) begin
        n.rdata = s_reg.div[15:8];
      end
    end

    // Interrupt requests from the next flag values
    n.irq_e = n.tx_buffer_empty_flag && n.tx_empty_irq_enable;
    n.irq_c = n.tc && n.tx_complete_irq_enable;
  end

  // State register with reset constants
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      s_reg <= '0;
      s_reg.tx_buffer_empty_flag <= 1'b1;
      s_reg.tc <= 1'b1;
      s_reg.div <= `AST_DIV_RST;
      s_reg.tx_line <= 1'b1;
      s_reg.rx_sync1 <= 1'b1;
      s_reg.rx_sync2 <= 1'b1;
      s_reg.rx_prev <= 1'b1;
    end else begin
      s_reg <= n;
    end
  end

  assign RDATA        = s_reg.rdata;
  assign TX           = s_reg.tx_line;
  assign TX_OE        = s_reg.tx_oe;
  assign TX_EMPTY_IRQ = s_reg.irq_e;
  assign TX_DONE_IRQ  = s_reg.irq_c;

  // Checks on the transmitter and start detector
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RST);

  start_bit_low_a: assert property (
    (s_reg.tx_st == ast_pkg::TX_START) && (s_reg.kind != ast_pkg::FR_IDLE) |-> !TX)
    else $error("start bit not low");

  idle_line_high_a: assert property (
    s_reg.transmitter_enable_bit && (s_reg.tx_st == ast_pkg::TX_IDLE) |-> TX)
    else $error("idle line not high");

  empty_clear_a: assert property (
    $fell(s_reg.tx_buffer_empty_flag) |-> $past(dr_wr))
    else $error("empty flag cleared without data write");

  direct_load_a: assert property (
    dr_wr && tx_ready |=> s_reg.tx_buffer_empty_flag && (s_reg.tx_st == ast_pkg::TX_START) && !TX)
    else $error("idle write did not start a frame");

  complete_set_a: assert property (
    tx_step && (s_reg.tx_st == ast_pkg::TX_STOP) && (s_reg.tcnt == stop_len - 6'h01) && s_reg.tx_buffer_empty_flag
    |=> s_reg.tc)
    else $error("complete flag not set after stop");

  frozen_count_a: assert property (
    !s_reg.transmitter_enable_bit ##1 !s_reg.transmitter_enable_bit |-> $stable(s_reg.tcnt) && $stable(s_reg.tx_st))
    else $error("bit counter moved while disabled");

  preamble_a: assert property (
    ten_rise |=> (s_reg.kind == ast_pkg::FR_IDLE) && (s_reg.tx_st == ast_pkg::TX_START) && TX)
    else $error("no idle preamble after enable");

  abort_quiet_a: assert property (
    (s_reg.rx_st == ast_pkg::RX_START) ##1 (s_reg.rx_st == ast_pkg::RX_IDLE)
    |-> $stable(s_reg.nf) && $stable(s_reg.rxf))
    else $error("aborted start changed a flag");

  break_drop_a: assert property (
    $rose(s_reg.tx_st == ast_pkg::TX_STOP) && (s_reg.kind == ast_pkg::FR_BREAK)
    && !$past(WR && (ADDR == `AST_ADDR_CR2)) |-> !s_reg.send_break_request)
    else $error("break request not cleared in stop bit");

  break_cov: cover property ($rose(s_reg.tx_st == ast_pkg::TX_STOP) && (s_reg.kind == ast_pkg::FR_BREAK));
  noise_cov: cover property ($rose(s_reg.nf));
  done_cov: cover property ($rose(s_reg.tc));

endmodule : ast_top

`default_nettype wire

//--- inc/ast_map.svh
`ifndef AST_MAP_SVH
`define AST_MAP_SVH

// Register offsets on the plain register port
`define AST_ADDR_SR      3'h0
`define AST_ADDR_DR      3'h1
`define AST_ADDR_CR1     3'h2
`define AST_ADDR_CR2     3'h3
`define AST_ADDR_CR3     3'h4
`define AST_ADDR_DIVL    3'h5
`define AST_ADDR_DIVH    3'h6

// Status register bit positions
`define AST_SR_TXE       3'h7
`define AST_SR_TC        3'h6
`define AST_SR_RXF       3'h5
`define AST_SR_NF        3'h2

// Control register one bit positions
`define AST_CR1_RX9      3'h7
`define AST_CR1_TX9      3'h6
`define AST_CR1_M        3'h4

// Control register two bit positions
`define AST_CR2_TX_EMPTY_IRQ_ENABLE     3'h7
`define AST_CR2_TX_COMPLETE_IRQ_ENABLE    3'h6
`define AST_CR2_TEN      3'h3
`define AST_CR2_REN      3'h2
`define AST_CR2_SBK      3'h0

// Control register three stop-count field and its codes
`define AST_CR3_STOP_MSB 3'h5
`define AST_CR3_STOP_LSB 3'h4
`define AST_STOP_ONE     2'h0
`define AST_STOP_TWO     2'h2
`define AST_STOP_ONEHALF 2'h3

// Timing in oversampling ticks (sixteen per bit)
`define AST_BIT_LAST     6'h0f
`define AST_STOP1_TICKS  6'h10
`define AST_STOP15_TICKS 6'h18
`define AST_STOP2_TICKS  6'h20
`define AST_BRK1_TICKS   6'h20
`define AST_BRK2_TICKS   6'h30
`define AST_SMP_A1       4'h5
`define AST_SMP_A2       4'h7
`define AST_SMP_B0       4'h8
`define AST_SMP_B1       4'h9
`define AST_SMP_B2       4'ha
`define AST_SMP_EDGE     4'h3

// Reset values
`define AST_DIV_RST      16'h0010

`endif

//--- inc/ast_pkg.sv
package ast_pkg;

  // Transmit sequencer states
  typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} ast_tx_e;

  // Kind of frame being sent
  typedef enum logic [1:0] {FR_DATA, FR_IDLE, FR_BREAK} ast_frame_e;

  // Receiver start-detect and data states
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} ast_rx_e;

  // Whole state of the top module
  typedef struct packed {
    logic             ten_q;
    logic             m;
    logic             tx9;
    logic             rx9;
    logic             send_break_request;
    logic             transmitter_enable_bit;
    logic             ren;
    logic             tx_empty_irq_enable;
    logic             tx_complete_irq_enable;
    logic [1:0]       stop;
    logic [15:0]      div;
    logic             tx_buffer_empty_flag;
    logic             tc;
    logic             tc_arm;
    logic [7:0]       hold;
    logic [8:0]       shift;
    ast_tx_e          tx_st;
    ast_frame_e       kind;
    logic [5:0]       tcnt;
    logic [3:0]       bidx;
    logic             rx_sync1;
    logic             rx_sync2;
    logic             rx_prev;
    ast_rx_e          rx_st;
    logic [3:0]       scnt;
    logic [1:0]       zcnt;
    logic             rnoise;
    logic [8:0]       rshift;
    logic [3:0]       rbits;
    logic [7:0]       rx_data;
    logic             rxf;
    logic             nf;
    logic             nf_arm;
    logic             tx_line;
    logic             tx_oe;
    logic [7:0]       rdata;
    logic             irq_e;
    logic             irq_c;
  } ast_state_s;

endpackage : ast_pkg

//--- design/ast_tick_gen.sv
`timescale 1ns/1ps
`default_nettype none

// Oversampling tick divider: one pulse every div/16 system clocks
module ast_tick_gen #(
  parameter int W = 16
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         en,
  input  wire logic         clr,
  input  wire logic [W-1:0] div,
  output wire logic         tick
);

  // State of the divider
  typedef struct packed {
    logic [W-5:0] cnt;
    logic         tick;
  } ast_tick_s;

  ast_tick_s       s_reg;   // Registered state
  ast_tick_s       s_next;  // Next state
  logic [W-5:0]    per_m1;  // Period minus one, at least zero

  // A divider below sixteen still yields one tick per clock
  assign per_m1 = (div[W-1:4] == '0) ? '0 : div[W-1:4] - 1'b1;

  // Count while enabled, hold when frozen, restart on clear
  always_comb begin
    s_next = s_reg;
    s_next.tick = 1'b0;
    if (clr) begin
      s_next.cnt = '0;
    end else if (en) begin
      if (s_reg.cnt >= per_m1) begin
        s_next.cnt = '0;
        s_next.tick = 1'b1;
      end else begin
        s_next.cnt = s_reg.cnt + 1'b1;
      end
    end
  end

  // State register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign tick = s_reg.tick;

endmodule : ast_tick_gen

`default_nettype wire

//--- sim/ast_line_model.sv
`timescale 1ns/1ps
`default_nettype none
// Far serial device: samples TX frames at mid-bit and drives frames on RX
module ast_line_model (
  input  wire logic       clk,
  input  wire logic       tx,
  input  wire logic       nine,
  output logic            rx,
  output logic            got,
  output logic [9:0]      word
);
  logic [9:0] w;  // Frame being collected: stop, ninth, data
  int         i;  // Bit index
  initial begin
    rx   = 1'b1;
    got  = 1'b0;
    word = '0;
  end
  // One frame per falling edge, centred half a bit into the start bit
  always begin
    @(negedge tx);
    w = '0;
    repeat (8) @(posedge clk);
    for (i = 0; i < (nine ? 9 : 8); i++) begin
      repeat (16) @(posedge clk);
      w[i] = tx;
    end
    repeat (16) @(posedge clk);
    w[9] = tx;
    word <= w;
    got  <= 1'b1;
    @(posedge clk);
    got  <= 1'b0;
  end
  // Drive a frame: low start, LSB first, one high stop; blip > 0 puts one high clock into the start
  task automatic send(input logic [8:0] d, input int n, input int blip);
    int k;
    for (k = 0; k < 16; k++) begin
      rx <= (k == blip) && (k > 0);
      @(posedge clk);
    end
    for (k = 0; k < n; k++) begin
      rx <= d[k];
      repeat (16) @(posedge clk);
    end
    rx <= 1'b1;
    repeat (16) @(posedge clk);
  endtask : send
  // Short low pulse that must not pass as a start bit
  task automatic glitch;
    rx <= 1'b0;
    repeat (2) @(posedge clk);
    rx <= 1'b1;
    repeat (2) @(posedge clk);
  endtask : glitch
endmodule : ast_line_model
`default_nettype wire

//--- sim/ast_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
// Self-checking bench: registers by the plain port, serial via the model
module ast_top_tb;
  logic            SYS_CLK = 1'b0;
  logic            RST = 1'b1;
  logic      [2:0] ADDR = '0;
  logic      [7:0] WDATA = '0;
  logic            WR = 1'b0, RD = 1'b0, rd_d = 1'b0, nine = 1'b0;
  wire logic [7:0] RDATA;
  wire logic       TX, TX_OE, TX_EMPTY_IRQ, TX_DONE_IRQ, RX, got;
  wire logic [9:0] word;
  logic     [31:0] seed = 32'hcc89b8a6;  // Xorshift state
  logic      [7:0] q_reg[$];             // Expected read data
  logic      [9:0] q_word[$];            // Expected frames
  int              q_gap[$];             // Expected frame spacing, 0 = none
  int              fail_count = 0, check_count = 0, k, g, cyc = 0, last = 0, lows = 0;
  logic      [7:0] codes[4] = '{8'h00, 8'h20, 8'h30, 8'h00};  // Stop-count settings
  int              ticks[4] = '{16, 32, 24, 16};             // Stop length per setting
  always #50 SYS_CLK = ~SYS_CLK;
  ast_top u_ast_top (.SYS_CLK(SYS_CLK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
    .RDATA(RDATA), .RX(RX), .TX(TX), .TX_OE(TX_OE), .TX_EMPTY_IRQ(TX_EMPTY_IRQ), .TX_DONE_IRQ(TX_DONE_IRQ));
  ast_line_model u_ast_line_model (.clk(SYS_CLK), .tx(TX), .nine(nine), .rx(RX), .got(got), .word(word));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction : xs
  task cmp_val(input logic [15:0] a, input logic [15:0] e);
    check_count++;
    if (a !== e) begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, a, e);
    end
  endtask : cmp_val
  task cmp_word(input logic [9:0] a, input logic [9:0] e);
    cmp_val({6'h0, a}, {6'h0, e});
  endtask : cmp_word
  task wr(input logic [2:0] a, input logic [7:0] d);
    ADDR  <= a;
    WDATA <= d;
    WR    <= 1'b1;
    @(posedge SYS_CLK);
    WR    <= 1'b0;
    @(posedge SYS_CLK);
  endtask : wr
  task rd(input logic [2:0] a, input logic [7:0] e);
    q_reg.push_back(e);
    ADDR <= a;
    RD   <= 1'b1;
    @(posedge SYS_CLK);
    RD   <= 1'b0;
    @(posedge SYS_CLK);
  endtask : rd
  task ex(input logic [9:0] w, input int gp);
    q_word.push_back(w);
    q_gap.push_back(gp);
  endtask : ex
  task wait_tx;
    int n;
    for (n = 0; n < 9000 && q_word.size() > 0; n++) @(posedge SYS_CLK);
    repeat (40) @(posedge SYS_CLK);
  endtask : wait_tx
  // Direct load then a held word; spacing of the pair gives the stop length
  task pair(input int n, input int st);
    logic [7:0] a, c;
    seed = xs(seed);
    a = seed[7:0];
    c = seed[15:8];
    ex({1'b1, 1'(n == 9), a}, 0);
    ex({1'b1, 1'(n == 9), c}, 16 * (1 + n) + st + 1);
    rd(0, 8'hc0);
    wr(1, a);
    wr(1, c);
    rd(0, 8'h00);
    wait_tx;
    rd(0, 8'hc0);
  endtask : pair
  task done(input string s);
    $display("test %s finished", s);
  endtask : done
  task final_report;
    if (q_word.size() != 0) fail_count++;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : final_report
  // Result watcher: read data and received frames against the oldest note
  always @(negedge SYS_CLK) begin
    cyc++;
    if (rd_d) cmp_val({8'h0, RDATA}, {8'h0, q_reg.pop_front()});
    rd_d = RD;
    if (got && q_word.size() == 0) cmp_val({6'h0, word}, 16'hffff);
    else if (got) begin
      g = q_gap.pop_front();
      if (g != 0) cmp_val(16'(cyc - last), 16'(g));
      last = cyc;
      cmp_word(word, q_word.pop_front());
    end
  end
  // Watchdog
  initial begin
    repeat (40000) @(posedge SYS_CLK);
    fail_count++;
    final_report;
  end
  initial begin
    repeat (8) @(posedge SYS_CLK);
    RST <= 1'b0;
    @(posedge SYS_CLK);
    rd(0, 8'hc0);
    rd(7, 8'h00);
    done("reset");
    wr(3, 8'hcc);
    ex(10'h25a, 0);
    wr(1, 8'h5a);
    for (k = 0; k < 140; k++) begin
      @(posedge SYS_CLK);
      lows += !TX;
    end
    cmp_val(16'(lows), 16'h0);
    cmp_val({15'h0, TX_OE}, 16'h1);
    wait_tx;
    done("idle");
    for (k = 0; k < 4; k++) begin
      nine = (k == 3);
      wr(2, k == 3 ? 8'h50 : 8'h00);
      wr(4, codes[k]);
      pair(k == 3 ? 9 : 8, ticks[k]);
    end
    done("frames");
    nine = 1'b0;
    wr(2, 8'h00);
    wr(4, 8'h00);
    ex(10'h23c, 0);
    ex(10'h000, 0);
    wr(1, 8'h3c);
    wr(3, 8'hcd);
    wait_tx;
    rd(3, 8'hcc);
    rd(0, 8'hc0);
    ex(10'h2c3, 0);
    wr(1, 8'hc3);
    rd(0, 8'h80);
    wr(3, 8'hcd);
    wr(3, 8'hcc);
    wait_tx;
    @(negedge SYS_CLK);
    cmp_val({14'h0, TX_EMPTY_IRQ, TX_DONE_IRQ}, 16'h3);
    @(posedge SYS_CLK);
    wr(0, 8'h00);
    rd(0, 8'h80);
    done("break");
    for (k = 0; k < 3; k++) begin
      seed = xs(seed);
      u_ast_line_model.send({1'b0, seed[7:0]}, 8, 0);
      repeat (4) @(posedge SYS_CLK);
      rd(1, seed[7:0]);
    end
    wr(2, 8'h10);
    u_ast_line_model.send(9'h1a5, 9, 0);
    repeat (4) @(posedge SYS_CLK);
    rd(2, 8'h90);
    rd(1, 8'ha5);
    u_ast_line_model.glitch;
    repeat (40) @(posedge SYS_CLK);
    rd(0, 8'h80);
    u_ast_line_model.send(9'h0c3, 9, 7);
    repeat (4) @(posedge SYS_CLK);
    rd(0, 8'ha4);
    rd(1, 8'hc3);
    rd(0, 8'h80);
    done("receive");
    final_report;
  end
endmodule : ast_top_tb
`default_nettype wire
